// [lrx_pkg.sv]
// shared constants and types for the link receive control register group
package lrx_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_LINK_ERR = 8'h41;
    localparam logic [7:0] IDX_BC = 8'h43;
    localparam logic [7:0] IDX_EQ_BYP = 8'h44;
    localparam logic [7:0] IDX_EQ_FLOOR = 8'h45;
    localparam logic [7:0] IDX_PORT_CTL = 8'h60;
    localparam logic [7:0] IDX_STATUS = 8'h61;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h62;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h63;
    localparam logic [7:0] IDX_IRQ_EN = 8'h64;

    // ==========================================================
    // field positions
    localparam int LE_CNT_EN_BIT = 4;
    localparam int LE_THR_LSB = 0;
    localparam int BC_MISO_MODE_BIT = 4;
    localparam int BC_CPOL_BIT = 3;
    localparam int BC_MODE_LSB = 0;
    localparam int EQ_S1_LSB = 5;
    localparam int EQ_S2_LSB = 1;
    localparam int EQ_BYP_BIT = 0;
    localparam int EQ_FLOOR_LSB = 0;
    localparam int PC_PORT_SEL_BIT = 0;
    localparam int PC_FLOOR_EN_BIT = 1;
    localparam int IRQ_LOST_BIT = 0;
    localparam int IRQ_GAINED_BIT = 1;
    localparam int IRQ_ERR_BIT = 2;
    localparam int IRQ_W = 3;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_LINK_ERR = 8'h03;
    localparam logic [7:0] RST_BC = 8'h00;
    localparam logic [7:0] RST_EQ_BYP = 8'h60;
    localparam logic [7:0] RST_EQ_FLOOR = 8'h80;
    localparam logic [7:0] RST_PORT_CTL = 8'h00;
    localparam logic [2:0] RST_IRQ_EN = 3'h0;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        BC_NORMAL = 3'b000, BC_GPIO1 = 3'b001, BC_GPIO2 = 3'b010, BC_GPIO4 = 3'b011,
        BC_RSVD4 = 3'b100, BC_RSVD5 = 3'b101, BC_FWD_SPI = 3'b110, BC_REV_SPI = 3'b111
    } lrx_bc_mode_t;

    typedef enum logic {LK_HUNT = 1'b0, LK_LOCKED = 1'b1} lrx_lock_t;

    typedef struct packed {
        logic [2:0] gpio_count;
        logic fwd_spi;
        logic rev_spi;
        logic reserved;
    } lrx_bc_t;

    typedef struct packed {
        logic adapt_en;
        logic [5:0] manual;
        logic floor_en;
        logic [3:0] floor;
    } lrx_eq_t;

endpackage

// [lrx_regs.sv]
// link receive control registers: lock integrity, back-channel mode, equalizer
// Operation
// (RULE_01) count enabled: count link errors, drop lock when count reaches 4-bit threshold (3)
// (RULE_02) count disabled: first link error drops lock
// (RULE_03) error counter steps on pixel clock enable; watches both clocks and control channel
// (RULE_04) reverse SPI, drive-mode 1: float slave output while select low; 0 always drive
// (RULE_05) polarity 0: launch falling, sample rising; polarity 1: the reverse
// (RULE_06) mode 000 normal, 001/010/011 one/two/four fast GPIOs, 100/101 reserved
// (RULE_07) mode 110 forward SPI tunnel, 111 reverse SPI tunnel
// (RULE_08) equalizer bypass bit 1 stops self-tuning, 0 runs it
// (RULE_09) bypassed: manual six-bit setting, coarse bits 7:5 high, fine bits 3:1 low
// (RULE_10) second port select steers equalizer register accesses to the second port
// (RULE_11) floor enabled by pin or register: adaptation starts from the 4-bit floor
// (RULE_12) error counter cleared whenever lock is lost or regained
`timescale 1ns/1ps
module lrx_regs import lrx_pkg::*; (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // link integrity
    input wire logic PIX_CE,
    input wire logic [2:0] LINK_ERR,
    input wire logic LOCK_ACQ,
    output logic LOCK_OUT,
    // back-channel spi
    input wire logic SPI_SCLK,
    input wire logic SPI_SS,
    input wire logic SPI_MOSI,
    input wire logic SPI_MISO_DATA,
    output logic SPI_MISO_O,
    output logic SPI_MISO_OE_N,
    output logic SPI_TX_STB,
    output logic SPI_RX_BIT,
    output logic SPI_RX_STB,
    // back-channel mode and equalizers
    input wire logic FLOOR_PIN,
    output lrx_bc_t BC_CFG,
    output lrx_eq_t EQ_PORT0,
    output lrx_eq_t EQ_PORT1,
    // interrupt
    output logic IRQ
);

    // ==========================================================
    // apb decode
    logic setup;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic [7:0] link_err_ctl;
    logic [7:0] bc_ctl;
    logic [7:0] eq_byp [2];
    logic [7:0] eq_floor [2];
    logic [7:0] port_ctl;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [2:0] irq_set;
    logic port_sel;
    logic [31:0] next_rdata;
    logic next_err;
    lrx_lock_t lock_st;
    logic [3:0] err_cnt;
    logic sclk_q;
    lrx_bc_mode_t bc_mode;

    assign setup = PSEL && !PENABLE;
    assign wr = PSEL && PENABLE && PREADY && PWRITE;
    assign idx = PADDR[9:2];
    assign wbyte = PWDATA[7:0];
    assign port_sel = port_ctl[PC_PORT_SEL_BIT];
    assign bc_mode = lrx_bc_mode_t'(bc_ctl[BC_MODE_LSB +: 3]);

    // read mux; the equalizer pair shows the port chosen by the select bit
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (idx)
            IDX_LINK_ERR: next_rdata[7:0] = link_err_ctl;
            IDX_BC: next_rdata[7:0] = bc_ctl;
            IDX_EQ_BYP: next_rdata[7:0] = eq_byp[port_sel]; // RULE_10
            IDX_EQ_FLOOR: next_rdata[7:0] = eq_floor[port_sel]; // RULE_10
            IDX_PORT_CTL: next_rdata[7:0] = port_ctl;
            IDX_STATUS: next_rdata[3:0] = {err_cnt[2:0], lock_st == LK_LOCKED};
            IDX_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
            IDX_IRQ_CLR: next_rdata = 32'h0000_0000;
            IDX_IRQ_EN: next_rdata[IRQ_W-1:0] = irq_en;
            default: next_err = 1'b1;
        endcase
        if (PADDR[1:0] != 2'b00 || PADDR[11:10] != 2'b00) begin
            next_err = 1'b1;
        end
    end

    // one registered answer per transfer, ready in the first access cycle
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= setup;
            PSLVERR <= setup && next_err;
            if (setup) begin
                PRDATA <= next_err ? 32'h0000_0000 : next_rdata;
            end
        end
    end

    // ==========================================================
    // control registers; an erroring write stores nothing
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            link_err_ctl <= RST_LINK_ERR;
            bc_ctl <= RST_BC;
            port_ctl <= RST_PORT_CTL;
            irq_en <= RST_IRQ_EN;
        end else if (wr && !PSLVERR) begin
            if (idx == IDX_LINK_ERR) link_err_ctl <= wbyte;
            if (idx == IDX_BC) bc_ctl <= wbyte;
            if (idx == IDX_PORT_CTL) port_ctl <= wbyte;
            if (idx == IDX_IRQ_EN) irq_en <= wbyte[IRQ_W-1:0];
        end
    end

    // ==========================================================
    // per-port equalizer registers and outputs
    for (genvar p = 0; p < 2; p++) begin : g_eq
        logic hit;
        lrx_eq_t next_eq;
        assign hit = wr && !PSLVERR && (port_sel == (p == 1)); // RULE_10
        always_ff @(posedge CLK_SYS or posedge RESET) begin
            if (RESET) begin
                eq_byp[p] <= RST_EQ_BYP;
                eq_floor[p] <= RST_EQ_FLOOR;
            end else begin
                if (hit && idx == IDX_EQ_BYP) eq_byp[p] <= wbyte;
                if (hit && idx == IDX_EQ_FLOOR) eq_floor[p] <= wbyte;
            end
        end
        // manual word is only meaningful while self-tuning is off
        always_comb begin
            next_eq.adapt_en = !eq_byp[p][EQ_BYP_BIT]; // RULE_08
            next_eq.manual = {eq_byp[p][EQ_S1_LSB +: 3], eq_byp[p][EQ_S2_LSB +: 3]}; // RULE_09
            next_eq.floor_en = FLOOR_PIN || port_ctl[PC_FLOOR_EN_BIT]; // RULE_11
            next_eq.floor = eq_floor[p][EQ_FLOOR_LSB +: 4]; // RULE_11
        end
        if (p == 0) begin : g_o0
            always_ff @(posedge CLK_SYS or posedge RESET) begin
                if (RESET) EQ_PORT0 <= '0;
                else EQ_PORT0 <= next_eq;
            end
        end else begin : g_o1
            always_ff @(posedge CLK_SYS or posedge RESET) begin
                if (RESET) EQ_PORT1 <= '0;
                else EQ_PORT1 <= next_eq;
            end
        end
    end

    // ==========================================================
    // lock keeper; all state moves only on pixel clock enables
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            lock_st <= LK_HUNT;
            LOCK_OUT <= 1'b0;
            err_cnt <= 4'h0;
        end else if (PIX_CE) begin // RULE_03
            case (lock_st)
                LK_HUNT: begin
                    if (LOCK_ACQ) begin
                        lock_st <= LK_LOCKED;
                        LOCK_OUT <= 1'b1;
                        err_cnt <= 4'h0; // RULE_12
                    end
                end
                LK_LOCKED: begin
                    if (|LINK_ERR) begin // RULE_03
                        if (!link_err_ctl[LE_CNT_EN_BIT] ||
                            (5'(err_cnt) + 5'd1 >= 5'(link_err_ctl[LE_THR_LSB +: 4]))) begin
                            lock_st <= LK_HUNT; // RULE_01 RULE_02
                            LOCK_OUT <= 1'b0;
                            err_cnt <= 4'h0; // RULE_12
                        end else begin
                            err_cnt <= err_cnt + 4'h1; // RULE_01
                        end
                    end
                end
                default: begin
                    lock_st <= LK_HUNT;
                    LOCK_OUT <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // interrupts: sticky status, set beats a same-cycle clear
    assign irq_set[IRQ_LOST_BIT] = PIX_CE && lock_st == LK_LOCKED && |LINK_ERR &&
        (!link_err_ctl[LE_CNT_EN_BIT] ||
         (5'(err_cnt) + 5'd1 >= 5'(link_err_ctl[LE_THR_LSB +: 4])));
    assign irq_set[IRQ_GAINED_BIT] = PIX_CE && lock_st == LK_HUNT && LOCK_ACQ;
    assign irq_set[IRQ_ERR_BIT] = PIX_CE && lock_st == LK_LOCKED && |LINK_ERR;

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            irq_stat <= 3'h0;
            IRQ <= 1'b0;
        end else begin
            irq_stat <= irq_set |
                (irq_stat & ~((wr && !PSLVERR && idx == IDX_IRQ_CLR) ? wbyte[2:0] : 3'h0));
            IRQ <= |(irq_stat & irq_en);
        end
    end

    // ==========================================================
    // back-channel mode decode, registered for the link logic
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            BC_CFG <= '0;
        end else begin
            BC_CFG.fwd_spi <= bc_mode == BC_FWD_SPI; // RULE_07
            BC_CFG.rev_spi <= bc_mode == BC_REV_SPI; // RULE_07
            BC_CFG.reserved <= bc_mode == BC_RSVD4 || bc_mode == BC_RSVD5; // RULE_06
            case (bc_mode) // RULE_06
                BC_GPIO1: BC_CFG.gpio_count <= 3'd1;
                BC_GPIO2: BC_CFG.gpio_count <= 3'd2;
                BC_GPIO4: BC_CFG.gpio_count <= 3'd4;
                default: BC_CFG.gpio_count <= 3'd0;
            endcase
        end
    end

    // ==========================================================
    // spi slave edges; sclk is taken as already synchronous
    logic spi_on;
    logic cpol;
    logic rise;
    logic fall;
    assign spi_on = (bc_mode == BC_FWD_SPI || bc_mode == BC_REV_SPI) && SPI_SS;
    assign cpol = bc_ctl[BC_CPOL_BIT];
    assign rise = SPI_SCLK && !sclk_q;
    assign fall = !SPI_SCLK && sclk_q;

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            sclk_q <= 1'b0;
            SPI_MISO_O <= 1'b0;
            SPI_TX_STB <= 1'b0;
            SPI_RX_BIT <= 1'b0;
            SPI_RX_STB <= 1'b0;
        end else begin
            sclk_q <= SPI_SCLK;
            SPI_TX_STB <= spi_on && (cpol ? rise : fall); // RULE_05
            SPI_RX_STB <= spi_on && (cpol ? fall : rise); // RULE_05
            if (spi_on && (cpol ? rise : fall)) SPI_MISO_O <= SPI_MISO_DATA; // RULE_05
            if (spi_on && (cpol ? fall : rise)) SPI_RX_BIT <= SPI_MOSI; // RULE_05
        end
    end

    // output enable is low while driving; outside reverse mode the pin is left alone
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) SPI_MISO_OE_N <= 1'b1;
        else SPI_MISO_OE_N <= !(bc_mode == BC_REV_SPI) ||
            (bc_ctl[BC_MISO_MODE_BIT] && !SPI_SS); // RULE_04
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    a_lock_first_err: assert property (PIX_CE && lock_st == LK_LOCKED && |LINK_ERR &&
        !link_err_ctl[LE_CNT_EN_BIT] |=> !LOCK_OUT && lock_st == LK_HUNT) // RULE_02
        else $error("lock kept after error with counting off");
    a_lock_below_thr: assert property (PIX_CE && lock_st == LK_LOCKED && |LINK_ERR &&
        link_err_ctl[LE_CNT_EN_BIT] && 5'(err_cnt) + 5'd1 < 5'(link_err_ctl[3:0])
        |=> LOCK_OUT && err_cnt == $past(err_cnt) + 4'h1) // RULE_01
        else $error("lock dropped below threshold");
    a_lock_at_thr: assert property (PIX_CE && lock_st == LK_LOCKED && |LINK_ERR &&
        link_err_ctl[LE_CNT_EN_BIT] && 5'(err_cnt) + 5'd1 >= 5'(link_err_ctl[3:0])
        |=> !LOCK_OUT) // RULE_01
        else $error("lock kept at threshold");
    a_cnt_pixel_rate: assert property (!PIX_CE |=> $stable(err_cnt) && $stable(LOCK_OUT)) // RULE_03
        else $error("counter moved without pixel enable");
    a_cnt_clear_edge: assert property ($changed(LOCK_OUT) |-> err_cnt == 4'h0) // RULE_12
        else $error("counter not cleared on lock change");
    a_miso_float: assert property (bc_mode == BC_REV_SPI && bc_ctl[BC_MISO_MODE_BIT] && !SPI_SS
        |=> SPI_MISO_OE_N) // RULE_04
        else $error("slave output driven while unselected");
    a_miso_drive: assert property (bc_mode == BC_REV_SPI && !bc_ctl[BC_MISO_MODE_BIT]
        |=> !SPI_MISO_OE_N) // RULE_04
        else $error("slave output not driven");
    a_spi_edges: assert property (spi_on && rise |=> SPI_TX_STB == $past(cpol) &&
        SPI_RX_STB == !$past(cpol)) // RULE_05
        else $error("spi edge roles wrong");
    a_gpio_decode: assert property (##1 BC_CFG.gpio_count == ($past(bc_mode) == BC_GPIO4 ? 3'd4 :
        $past(bc_mode) == BC_GPIO2 ? 3'd2 : $past(bc_mode) == BC_GPIO1 ? 3'd1 : 3'd0)) // RULE_06
        else $error("gpio count decode wrong");
    a_spi_tunnel: assert property (bc_mode == BC_REV_SPI |=> BC_CFG.rev_spi && !BC_CFG.fwd_spi) // RULE_07
        else $error("reverse tunnel not selected");
    // skip the edge right after reset release, where the output still holds its reset zero
    a_eq_bypass: assert property (!$past(RESET) |->
        EQ_PORT0.adapt_en != $past(eq_byp[0][EQ_BYP_BIT])) // RULE_08
        else $error("bypass not applied");
    a_eq_manual: assert property (wr && !PSLVERR && idx == IDX_EQ_BYP && !port_sel
        |=> ##1 EQ_PORT0.manual == {$past(wbyte[7:5], 2), $past(wbyte[3:1], 2)}) // RULE_09
        else $error("manual setting wrong");
    a_port_steer: assert property (wr && !PSLVERR && idx == IDX_EQ_BYP && port_sel
        |=> eq_byp[1] == $past(wbyte) && $stable(eq_byp[0])) // RULE_10
        else $error("second port write misrouted");
    a_floor_start: assert property (FLOOR_PIN |=> EQ_PORT1.floor_en) // RULE_11
        else $error("floor pin ignored");

    c_lock_lost: cover property (LOCK_OUT ##1 !LOCK_OUT);
    c_rev_spi_tx: cover property (BC_CFG.rev_spi && SPI_TX_STB);
    c_port1_write: cover property (wr && port_sel && idx == IDX_EQ_FLOOR);
    c_irq: cover property (IRQ);

endmodule

// [lrx_link_model.sv]
// remote serializer stand-in: pixel slots, link error flags, lock indication and spi pins
`timescale 1ns/1ps
module lrx_link_model (
    // clock
    input wire logic clk_sys,
    // link integrity toward the block
    output logic pix_ce,
    output logic [2:0] link_err,
    output logic lock_acq,
    // tunnelled spi pins
    output logic spi_sclk,
    output logic spi_ss,
    output logic spi_mosi,
    output logic spi_miso_data
);
    // idle levels at time zero
    initial begin
        pix_ce = 1'b0;
        link_err = 3'h0;
        lock_acq = 1'b0;
        spi_sclk = 1'b0;
        spi_ss = 1'b0;
        spi_mosi = 1'b0;
        spi_miso_data = 1'b0;
    end

    // one pixel slot after a gap; flags flip outside slots so stale values never pass as valid
    task automatic slot(input logic [2:0] err, input logic acq, input int gap);
        repeat (gap + 1) @(posedge clk_sys);
        pix_ce <= 1'b1;
        link_err <= err;
        lock_acq <= acq;
        @(posedge clk_sys);
        pix_ce <= 1'b0;
        link_err <= ~err;
        lock_acq <= ~acq;
    endtask

    // master moves clock, select and data together just after an edge
    task automatic spi_pins(input logic ss, input logic sclk, input logic mosi, input logic miso);
        @(posedge clk_sys);
        spi_ss <= ss;
        spi_sclk <= sclk;
        spi_mosi <= mosi;
        spi_miso_data <= miso;
    endtask
endmodule

// [lrx_regs_tb.sv]
// self-checking bench for the link receive control registers
`timescale 1ns/1ps
module lrx_regs_tb import lrx_pkg::*;;
    // ==========================================================
    // signals and instances
    logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, floor_pin, err;
    logic pix_ce, lock_acq, lock_out, sclk, ss, mosi, miso_data;
    logic miso_o, miso_oe_n, tx_stb, rx_bit, rx_stb, irq;
    logic [2:0] link_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] rd, v, w;
    lrx_bc_t bc_cfg;
    lrx_eq_t eq0, eq1;
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 32'h6bc8_4a2d;
    logic [7:0] ridx [6] = '{IDX_LINK_ERR, IDX_BC, IDX_EQ_BYP, IDX_EQ_FLOOR, IDX_PORT_CTL,
        IDX_IRQ_EN};
    logic [7:0] rval [6] = '{RST_LINK_ERR, RST_BC, RST_EQ_BYP, RST_EQ_FLOOR, RST_PORT_CTL,
        8'h00};
    logic [3:0] thr [4] = '{4'h3, 4'h3, 4'h1, 4'hf};

    lrx_regs lrx_regs_i (.CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PIX_CE(pix_ce), .LINK_ERR(link_err), .LOCK_ACQ(lock_acq),
        .LOCK_OUT(lock_out), .SPI_SCLK(sclk), .SPI_SS(ss), .SPI_MOSI(mosi),
        .SPI_MISO_DATA(miso_data), .SPI_MISO_O(miso_o), .SPI_MISO_OE_N(miso_oe_n),
        .SPI_TX_STB(tx_stb), .SPI_RX_BIT(rx_bit), .SPI_RX_STB(rx_stb), .FLOOR_PIN(floor_pin),
        .BC_CFG(bc_cfg), .EQ_PORT0(eq0), .EQ_PORT1(eq1), .IRQ(irq));
    lrx_link_model lrx_link_model_i (.clk_sys(clk_sys), .pix_ce(pix_ce), .link_err(link_err),
        .lock_acq(lock_acq), .spi_sclk(sclk), .spi_ss(ss), .spi_mosi(mosi),
        .spi_miso_data(miso_data));

    // 200 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // checking helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic lrx_bc_t exp_bc(input logic [2:0] m);
        lrx_bc_t b;
        b.gpio_count = (m == 3'b001) ? 3'd1 : (m == 3'b010) ? 3'd2 : (m == 3'b011) ? 3'd4 : 3'd0;
        b.fwd_spi = (m == 3'b110);
        b.rev_spi = (m == 3'b111);
        b.reserved = (m == 3'b100) || (m == 3'b101);
        return b;
    endfunction

    // {adapt_en, manual} expected from a bypass word
    function automatic logic [6:0] exp_man(input logic [7:0] b);
        return {~b[0], b[7:5], b[3:1]};
    endfunction

    // ==========================================================
    // drivers
    // apb transfer; waits for pready (a hang is left to the watchdog), result in rd and err
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [8:0] exp);
        apb(1'b0, idx, 8'h00);
        chk({23'h0, err, rd}, {23'h0, exp});
    endtask

    // one pixel slot, then lock level compared
    task automatic step(input logic [2:0] e, input logic a, input logic exp);
        lrx_link_model_i.slot(e, a, $random(seed) & 3);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, lock_out}, {31'h0, exp});
    endtask

    // one spi pin change, strobes {tx, rx} gathered over four cycles
    task automatic spi_edge(input logic s, input logic c, input logic d, input logic [1:0] ex);
        logic [1:0] seen;
        seen = 2'b00;
        lrx_link_model_i.spi_pins(s, c, d, ~d);
        repeat (4) begin
            @(posedge clk_sys);
            #1;
            seen = seen | {tx_stb, rx_stb};
            if (tx_stb === 1'b1) chk({31'h0, miso_o}, {31'h0, ~d});
            if (rx_stb === 1'b1) chk({31'h0, rx_bit}, {31'h0, d});
        end
        chk({30'h0, seen}, {30'h0, ex});
    endtask

    // ==========================================================
    // main sequence
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        floor_pin = 1'b0;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) rdc(ridx[i], {1'b0, rval[i]});
        chk(32'(eq0), {20'h0, exp_man(RST_EQ_BYP), 5'h00});
        rdc(8'h42, 9'h100);
        rdc(IDX_IRQ_CLR, 9'h000);
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            apb(1'b1, i[0] ? IDX_EQ_FLOOR : IDX_LINK_ERR, v);
            rdc(i[0] ? IDX_EQ_FLOOR : IDX_LINK_ERR, {1'b0, v});
        end
        // every back-channel code, all decoded fields compared
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, IDX_BC, 8'(m));
            repeat (2) @(posedge clk_sys);
            chk(32'(bc_cfg), 32'(exp_bc(3'(m))));
        end
        // equalizers: per-port steering, manual setting, floor by register and by pin
        v = 8'($random(seed));
        w = ~v;
        apb(1'b1, IDX_EQ_BYP, v);
        apb(1'b1, IDX_EQ_FLOOR, w);
        apb(1'b1, IDX_PORT_CTL, 8'h01);
        apb(1'b1, IDX_EQ_BYP, w);
        apb(1'b1, IDX_EQ_FLOOR, v);
        repeat (2) @(posedge clk_sys);
        chk(32'(eq0[11:5]), 32'(exp_man(v)));
        chk(32'(eq1[11:5]), 32'(exp_man(w)));
        rdc(IDX_EQ_BYP, {1'b0, w});
        apb(1'b1, IDX_PORT_CTL, 8'h02);
        rdc(IDX_EQ_BYP, {1'b0, v});
        chk(32'(eq0[4:0]), {27'h0, 1'b1, w[3:0]});
        chk(32'(eq1[4:0]), {27'h0, 1'b1, v[3:0]});
        apb(1'b1, IDX_PORT_CTL, 8'h00);
        floor_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({31'h0, eq0.floor_en}, 32'h1);
        floor_pin <= 1'b0;
        // lock, interrupt raise, clear and mask
        apb(1'b1, IDX_IRQ_EN, 8'h07);
        apb(1'b1, IDX_LINK_ERR, 8'h03);
        step(3'b111, 1'b0, 1'b0);
        step(3'b000, 1'b1, 1'b1);
        chk({31'h0, irq}, 32'h1);
        rdc(IDX_IRQ_STAT, 9'h002);
        apb(1'b1, IDX_IRQ_CLR, 8'h07);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        step(3'b010, 1'b0, 1'b0);
        apb(1'b0, IDX_IRQ_STAT, 8'h00);
        chk({31'h0, rd[IRQ_LOST_BIT]}, 32'h1);
        apb(1'b1, IDX_IRQ_EN, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, IDX_IRQ_CLR, 8'h07);
        // thresholds, a fresh count after every relock, errors rotated over the channels
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, IDX_LINK_ERR, {4'h1, thr[t]});
            step(3'b000, 1'b1, 1'b1);
            for (int k = 1; k < thr[t]; k++) step(3'b001 << (k % 3), k[0], 1'b1);
            rdc(IDX_STATUS, {5'h00, 3'(thr[t] - 4'h1), 1'b1});
            step(3'b100, 1'b0, 1'b0);
        end
        // spi tunnel: drive modes, both polarities, refused edges
        apb(1'b1, IDX_BC, 8'h17);
        spi_edge(1'b0, 1'b1, 1'b0, 2'b00);
        chk({31'h0, miso_oe_n}, 32'h1);
        spi_edge(1'b1, sclk, 1'b0, 2'b00);
        for (int c = 0; c < 2; c++) begin
            apb(1'b1, IDX_BC, {4'h1, c[0], 3'b111});
            for (int k = 0; k < 6; k++) begin
                v = 8'($random(seed));
                spi_edge(1'b1, ~sclk, v[0], (~sclk == c[0]) ? 2'b10 : 2'b01);
            end
            chk({31'h0, miso_oe_n}, 32'h0);
        end
        apb(1'b1, IDX_BC, 8'h07);
        spi_edge(1'b0, ~sclk, 1'b0, 2'b00);
        chk({31'h0, miso_oe_n}, 32'h0);
        apb(1'b1, IDX_BC, 8'h10);
        spi_edge(1'b1, ~sclk, 1'b1, 2'b00);
        chk({31'h0, miso_oe_n}, 32'h1);
        results();
    end

    // watchdog: the sequence needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        results();
    end
endmodule
